// ### logic/otdc_pkg.sv
/*
 * constants, field layout and mode encodings of the output tap delay
 * control block.
 * assumes one 100 MHz control clock and a classic wishbone register port.
 */
package otdc_pkg;

    // ****************************************************************
    // delay line geometry
    // ****************************************************************
    localparam int TAP_W = 9;
    localparam int NUM_TAPS = 512;
    localparam logic [8:0] TAP_ZERO = 9'h000;
    localparam logic [8:0] TAP_LAST = 9'h1ff;
    localparam int INIT_W = 11;
    localparam logic [10:0] MAX_TIME_PS = 11'h04e2;

    // ****************************************************************
    // calibration reference
    // ****************************************************************
    localparam int CALIB_REFERENCE_RATE_MHZ = 300;
    localparam int REF_TAPS_PER_PERIOD = 256;
    localparam int REF_PERIOD_PS = 1_000_000 / CALIB_REFERENCE_RATE_MHZ;
    localparam logic [10:0] TAP_PS = 11'(REF_PERIOD_PS / REF_TAPS_PER_PERIOD);

    // ****************************************************************
    // chain insertion delay
    // ****************************************************************
    localparam logic [15:0] INS_BASE_PS = 16'h0064;
    localparam logic [15:0] INS_STAGE_PS = 16'h0032;
    localparam logic [2:0] BYTE_LAST = 3'h7;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_INIT = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_CHAIN = 4'hc;

    localparam int CTRL_STYLE_LSB = 0;
    localparam int CTRL_FMT_BIT = 2;
    localparam int CTRL_CHAIN_LSB = 3;
    localparam int CTRL_BPOS_LSB = 5;
    localparam int CTRL_CLEN_LSB = 8;
    localparam int CTRL_REINIT_BIT = 11;

    localparam int ST_READY_BIT = 9;
    localparam int ST_COMP_BIT = 10;
    localparam int ST_CHOK_BIT = 11;
    localparam int ST_SLICE_BIT = 12;

    // ****************************************************************
    // modes
    // ****************************************************************
    typedef enum logic [1:0] {
        STYLE_FIXED = 2'h0,
        STYLE_STEP = 2'h1,
        STYLE_LOAD = 2'h2
    } otdc_style_t;

    typedef enum logic {
        FMT_TIME = 1'h0,
        FMT_COUNT = 1'h1
    } otdc_fmt_t;

    typedef enum logic [1:0] {
        CHAIN_NONE = 2'h0,
        CHAIN_HEAD = 2'h1,
        CHAIN_MIDDLE = 2'h2,
        CHAIN_END = 2'h3
    } otdc_chain_t;

endpackage

// ### logic/otdc_delay_line.sv
/*
 * tapped delay line: one register stage per tap, output picked by tap.
 * assumes data and tap both on core_clk.
 */
`timescale 1ns/1ps
module otdc_delay_line
    import otdc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // data path
    input wire logic data_in,
    input wire logic [otdc_pkg::TAP_W-1:0] tap,
    input wire logic borrowed,
    output logic data_out
);

    typedef struct packed {
        logic [NUM_TAPS-1:0] line;
        logic out;
    } otdc_dl_state_t;

    otdc_dl_state_t s_q;
    otdc_dl_state_t s_d;

    always_comb begin
        s_d.line = {s_q.line[NUM_TAPS-2:0], data_in};
        // a borrowed element no longer carries its own data
        s_d.out = borrowed ? 1'b0 : s_q.line[tap];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign data_out = s_q.out;

endmodule // otdc_delay_line

// ### logic/otdc_top.sv
/*
 * output tap delay control: tap register, step and load control, vt
 * compensation adjust, delay line, wishbone register file.
 * assumes fabric controls on core_clk; vt_comp_enable and calib_ready
 * arrive asynchronously; calibration adjust pulses on core_clk.
 */
// What this block does
// R01: tap_value_in is the absolute tap count taken on a load.
// R02: fabric puts the new tap value up one cycle before load.
// R03: fabric moves the line one to eight taps per update.
// R04: tap_value_out always shows the tap currently selected.
// R05: with compensation on, reported taps follow calibration adjustments.
// R06: asynchronous reset returns the line to the initial delay setting.
// R07: fabric waits for calibration ready before normal use.
// R08: compensation enable high adjusts taps for vt in time format only; low does nothing.
// R09: fabric holds compensation enable low while loading or stepping.
// R10: input data leaves delayed_output after the selected delay.
// R11: style is fixed, stepping or loadable; fixed by default.
// R12: time format setting is 0 to 1250 ps, default zero.
// R13: count format setting is used directly as the starting tap.
// R14: format defaults to time; delay equals ps against reference clock.
// R15: reference rate must match the calibration clock applied.
// R16: time format calibration reserves neighbouring slices in the nibble.
// R17: chain position is none, head, middle or end.
// R18: chaining only valid when delay exceeds one element's maximum.
// R19: a borrowed chain member no longer carries its own data.
// R20: chain goes upward from head and stops at byte boundary.
// R21: chain insertion delay is base plus fixed amount per stage.
// R22: stepping wraps from last tap to zero and back.
// R23: step enable moves one tap per edge, direction by step_up.
// R24: loadable style load copies tap_value_in into the tap.
// R25: fabric keeps step enable low while asserting load.
// R26: fixed style ignores load and step; tap moves only on reinit or compensation adjust.
`timescale 1ns/1ps
module otdc_top
    import otdc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [otdc_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // fabric tap control
    input wire logic [otdc_pkg::TAP_W-1:0] tap_value_in,
    input wire logic tap_load,
    input wire logic step_enable,
    input wire logic step_up,
    output logic [otdc_pkg::TAP_W-1:0] tap_value_out,
    // calibration controller
    input wire logic vt_comp_enable,
    input wire logic calib_ready,
    input wire logic vt_adj_req,
    input wire logic vt_adj_up,
    // data path
    input wire logic delay_data_in,
    output logic delayed_output
);

    import otdc_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [1:0] style;
        logic fmt;
        logic [1:0] chain;
        logic [2:0] bpos;
        logic [2:0] clen;
        logic [INIT_W-1:0] init;
        logic [TAP_W-1:0] tap;
        logic vt_s1;
        logic vt_s2;
        logic rdy_s1;
        logic rdy_s2;
        logic ack;
        logic [31:0] dat;
    } otdc_state_t;

    otdc_state_t s_q;
    otdc_state_t s_d;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [TAP_W-1:0] init_taps(input logic fmt,
                                                   input logic [INIT_W-1:0] init);
        logic [INIT_W-1:0] ps;
        ps = (init > MAX_TIME_PS) ? MAX_TIME_PS : init;
        if (fmt == FMT_COUNT) begin
            init_taps = init[TAP_W-1:0];
        end else begin
            init_taps = TAP_W'(ps / TAP_PS);
        end
    endfunction

    function automatic logic [TAP_W-1:0] step_tap(input logic [TAP_W-1:0] tap,
                                                  input logic up);
        // natural 9-bit wrap in both directions
        step_tap = up ? TAP_W'(tap + 1'b1) : TAP_W'(tap - 1'b1);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (wdat & m);
    endfunction

    // ****************************************************************
    // decoded controls
    // ****************************************************************
    logic wb_hit;
    logic wr_now;
    logic comp_on;
    logic comp_adj;
    logic borrowed;
    logic chain_ok;
    logic slice_rsvd;
    logic reinit;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [31:0] init_new;
    logic [31:0] status_word;
    logic [15:0] ins_delay;
    logic [2:0] chain_room;

    always_comb begin
        wb_hit = wb_cyc_i & wb_stb_i;
        // write lands on the edge where the master sees ack
        wr_now = wb_hit & s_q.ack & wb_we_i;
        comp_on = s_q.vt_s2 & (s_q.fmt == FMT_TIME); // [R08]
        comp_adj = comp_on & vt_adj_req; // [R05]
        borrowed = (s_q.chain == CHAIN_MIDDLE) || (s_q.chain == CHAIN_END); // [R19]
        chain_room = BYTE_LAST - s_q.bpos; // [R20]
        chain_ok = (s_q.chain == CHAIN_NONE) ||
                   ((s_q.fmt == FMT_TIME) && (s_q.init > MAX_TIME_PS) &&
                    (s_q.clen <= chain_room)); // [R18] [R20]
        ins_delay = INS_BASE_PS + 16'(INS_STAGE_PS * s_q.clen); // [R21]
        slice_rsvd = (s_q.fmt == FMT_TIME); // [R16]
        ctrl_word = '0;
        ctrl_word[CTRL_STYLE_LSB +: 2] = s_q.style;
        ctrl_word[CTRL_FMT_BIT] = s_q.fmt;
        ctrl_word[CTRL_CHAIN_LSB +: 2] = s_q.chain; // [R17]
        ctrl_word[CTRL_BPOS_LSB +: 3] = s_q.bpos;
        ctrl_word[CTRL_CLEN_LSB +: 3] = s_q.clen;
        ctrl_new = merge(ctrl_word, wb_dat_i, wb_sel_i);
        init_new = merge({21'h0, s_q.init}, wb_dat_i, wb_sel_i);
        reinit = wr_now && (wb_adr_i == REG_CTRL) && ctrl_new[CTRL_REINIT_BIT];
        status_word = '0;
        status_word[TAP_W-1:0] = s_q.tap;
        status_word[ST_READY_BIT] = s_q.rdy_s2;
        status_word[ST_COMP_BIT] = comp_on;
        status_word[ST_CHOK_BIT] = chain_ok;
        status_word[ST_SLICE_BIT] = slice_rsvd;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.vt_s1 = vt_comp_enable;
        s_d.vt_s2 = s_q.vt_s1;
        s_d.rdy_s1 = calib_ready;
        s_d.rdy_s2 = s_q.rdy_s1;

        // bus answer one cycle after the request
        s_d.ack = wb_hit & ~s_q.ack;
        s_d.dat = '0;
        if (wb_hit && !s_q.ack && !wb_we_i) begin
            unique case (wb_adr_i)
                REG_CTRL: s_d.dat = ctrl_word;
                REG_INIT: s_d.dat = {21'h0, s_q.init};
                REG_STATUS: s_d.dat = status_word;
                REG_CHAIN: s_d.dat = {16'h0, ins_delay};
                default: s_d.dat = '0;
            endcase
        end

        if (wr_now) begin
            unique case (wb_adr_i)
                REG_CTRL: begin
                    s_d.style = ctrl_new[CTRL_STYLE_LSB +: 2]; // [R11]
                    s_d.fmt = ctrl_new[CTRL_FMT_BIT]; // [R14]
                    s_d.chain = ctrl_new[CTRL_CHAIN_LSB +: 2];
                    s_d.bpos = ctrl_new[CTRL_BPOS_LSB +: 3];
                    s_d.clen = ctrl_new[CTRL_CLEN_LSB +: 3];
                end
                REG_INIT: s_d.init = init_new[INIT_W-1:0];
                default: begin
                end
            endcase
        end

        // tap selection, highest priority first
        if (reinit) begin
            s_d.tap = init_taps(ctrl_new[CTRL_FMT_BIT], s_q.init); // [R12] [R13]
        end else if (comp_adj) begin
            s_d.tap = step_tap(s_q.tap, vt_adj_up); // [R05] [R08]
        end else if (s_q.style == STYLE_LOAD && tap_load) begin
            s_d.tap = tap_value_in; // [R01] [R24]
        end else if ((s_q.style == STYLE_STEP || s_q.style == STYLE_LOAD) &&
                     step_enable) begin
            s_d.tap = step_tap(s_q.tap, step_up); // [R22] [R23]
        end
        // fixed style falls through and keeps its tap [R26]
    end

    // reset values equal the defaults: fixed, time, zero ps, zero taps
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0; // [R06]
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // delay line and outputs
    // ****************************************************************
    otdc_delay_line u_line (
        .core_clk(core_clk),
        .rstn(rstn),
        .data_in(delay_data_in),
        .tap(s_q.tap),
        .borrowed(borrowed),
        .data_out(delayed_output) // [R10]
    );

    assign tap_value_out = s_q.tap; // [R04]
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.dat;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    logic quiet;
    assign quiet = !reinit && !comp_adj;

    property p_load;
        (s_q.style == STYLE_LOAD) && tap_load && quiet
            |=> tap_value_out == $past(tap_value_in);
    endproperty
    a_load: assert property (p_load) // [R24]
        else $error("load did not copy tap value");

    property p_step;
        (s_q.style == STYLE_STEP) && step_enable && step_up && quiet
            ##1 (s_q.style == STYLE_STEP) && step_enable && step_up && quiet
            |=> tap_value_out == TAP_W'($past(tap_value_out, 2) + 2'h2);
    endproperty
    a_step: assert property (p_step) // [R23]
        else $error("two up steps did not add two taps");

    property p_step_down;
        (s_q.style == STYLE_STEP) && step_enable && !step_up && quiet
            |=> tap_value_out == TAP_W'($past(tap_value_out) - 1'b1);
    endproperty
    a_step_down: assert property (p_step_down) // [R23]
        else $error("down step did not remove one tap");

    property p_wrap;
        (s_q.style == STYLE_STEP) && step_enable && step_up && quiet &&
            (tap_value_out == TAP_LAST) |=> tap_value_out == TAP_ZERO;
    endproperty
    a_wrap: assert property (p_wrap) // [R22]
        else $error("step up from last tap did not wrap to zero");

    property p_fixed;
        (s_q.style == STYLE_FIXED) && quiet |=> $stable(tap_value_out);
    endproperty
    a_fixed: assert property (p_fixed) // [R26]
        else $error("fixed style tap moved");

    property p_comp;
        comp_adj && !reinit && vt_adj_up
            |=> tap_value_out == TAP_W'($past(tap_value_out) + 1'b1);
    endproperty
    a_comp: assert property (p_comp) // [R05]
        else $error("compensation adjust not reported");

    property p_nocomp;
        !s_q.vt_s2 && vt_adj_req && !reinit && !tap_load && !step_enable
            |=> $stable(tap_value_out);
    endproperty
    a_nocomp: assert property (p_nocomp) // [R08]
        else $error("tap moved with compensation disabled");

    property p_cntfmt;
        (s_q.fmt == FMT_COUNT) && vt_adj_req && !reinit && !tap_load && !step_enable
            |=> $stable(tap_value_out);
    endproperty
    a_cntfmt: assert property (p_cntfmt) // [R08]
        else $error("tap moved on adjust in count format");

    property p_rd_status;
        wb_hit && !wb_ack_o && !wb_we_i && (wb_adr_i == REG_STATUS)
            |=> wb_dat_o[TAP_W-1:0] == $past(tap_value_out);
    endproperty
    a_rd_status: assert property (p_rd_status) // [R04]
        else $error("status read did not report current tap");

    property p_reinit;
        reinit |=> tap_value_out == init_taps(s_q.fmt, s_q.init);
    endproperty
    a_reinit: assert property (p_reinit) // [R13]
        else $error("reinit did not restore initial taps");

    property p_ack;
        wb_hit && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not a single cycle pulse");

    property p_borrow;
        borrowed |=> !delayed_output;
    endproperty
    a_borrow: assert property (p_borrow) // [R19]
        else $error("borrowed element still drives data");

    property p_delay0;
        $past(rstn) && (tap_value_out == TAP_ZERO) && !borrowed
            |=> delayed_output == $past(delay_data_in, 2);
    endproperty
    a_delay0: assert property (p_delay0) // [R10]
        else $error("zero tap delay wrong");

    property p_range;
        reinit && (ctrl_new[CTRL_FMT_BIT] == FMT_TIME)
            |=> tap_value_out <= TAP_W'(MAX_TIME_PS / TAP_PS);
    endproperty
    a_range: assert property (p_range) // [R12]
        else $error("time setting exceeded maximum");

endmodule // otdc_top

// ### verif/otdc_fabric_model.sv
/*
 * partner model: output serializer pattern source and calibration controller.
 * assumes core_clk and rstn of the bench; adjust pulses on request.
 */
`timescale 1ns/1ps
module otdc_fabric_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // bench requests
    input wire logic adj_go,
    input wire logic adj_dir,
    // towards the block
    output logic delay_data_in,
    output logic calib_ready,
    output logic vt_adj_req,
    output logic vt_adj_up
);
    logic [6:0] pat_q;
    logic [3:0] rdy_cnt_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pat_q <= 7'h01;
            rdy_cnt_q <= 4'h0;
            vt_adj_req <= 1'b0;
            vt_adj_up <= 1'b0;
        end else begin
            pat_q <= {pat_q[5:0], pat_q[6] ^ pat_q[5]};
            if (rdy_cnt_q != 4'hf) begin
                rdy_cnt_q <= rdy_cnt_q + 4'h1;
            end
            vt_adj_req <= adj_go;
            vt_adj_up <= adj_dir;
        end
    end

    assign delay_data_in = pat_q[0];
    // ready only after a settling span
    assign calib_ready = (rdy_cnt_q == 4'hf);
endmodule // otdc_fabric_model

// ### verif/otdc_top_tb.sv
/*
 * self-checking bench of the output tap delay control block.
 * assumes the fabric model beside it and a 100 MHz core_clk.
 */
`timescale 1ns/1ps
module otdc_top_tb;
    import otdc_pkg::*;
    logic core_clk, rstn, cyc, stb, we, ack, load, sen, sup, vten;
    logic din, dout, crdy, adj, adj_up, adj_go, adj_dir;
    logic [3:0] adr, sel;
    logic [31:0] wdat, rdat, rd;
    logic [8:0] tin, tout;
    logic [511:0] hist;
    int n_errors, checks_done;

    otdc_top i_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .tap_value_in(tin), .tap_load(load), .step_enable(sen),
        .step_up(sup), .tap_value_out(tout), .vt_comp_enable(vten), .calib_ready(crdy),
        .vt_adj_req(adj), .vt_adj_up(adj_up), .delay_data_in(din), .delayed_output(dout));

    otdc_fabric_model i_model (.core_clk(core_clk), .rstn(rstn), .adj_go(adj_go),
        .adj_dir(adj_dir), .delay_data_in(din), .calib_ready(crdy), .vt_adj_req(adj),
        .vt_adj_up(adj_up));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge core_clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk);
        chk({31'h0, ack}, 32'h0, "ack not dropped");
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd & m, e, "read");
    endtask

    task automatic look(input logic [8:0] e);
        #1;
        chk({23'h0, tout}, {23'h0, e}, "tap");
        @(posedge core_clk);
    endtask

    task automatic load_tap(input logic [8:0] v);
        tin <= v;
        @(posedge core_clk);
        load <= 1'b1;
        @(posedge core_clk);
        load <= 1'b0;
    endtask

    task automatic step(input logic u, input int n);
        sen <= 1'b1;
        sup <= u;
        repeat (n) @(posedge core_clk);
        sen <= 1'b0;
    endtask

    task automatic vt_adj(input logic u);
        adj_go <= 1'b1;
        adj_dir <= u;
        @(posedge core_clk);
        adj_go <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        hist <= {hist[510:0], din};
    end

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        #20_000;
        n_errors++;
        close_out();
    end

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        {rstn, cyc, stb, we, load, sen, sup, vten, adj_go, adj_dir} = '0;
        {adr, sel, wdat, tin, hist} = '0;
        n_errors = 0;
        checks_done = 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (40) if (crdy !== 1'b1) @(posedge core_clk);
        look(9'h000);
        rd_chk(REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd_chk(REG_CHAIN, 32'hffff_ffff, 32'h0000_0064);
        rd_chk(4'h2, 32'hffff_ffff, 32'h0000_0000);
        load_tap(9'h005);
        step(1'b1, 2);
        look(9'h000);
        wb(1'b1, REG_CTRL, 32'h0000_0002);
        load_tap(9'h008);
        look(9'h008);
        step(1'b1, 3);
        look(9'h00b);
        step(1'b0, 8);
        @(posedge core_clk);
        #1;
        for (int i = 0; i < 8; i++) begin
            chk({31'h0, dout}, {31'h0, hist[4]}, "data");
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        load_tap(9'h000);
        step(1'b0, 1);
        look(TAP_LAST);
        step(1'b1, 1);
        look(TAP_ZERO);
        wb(1'b1, REG_CTRL, 32'h0000_0001);
        load_tap(9'h007);
        step(1'b1, 2);
        look(9'h002);
        vten <= 1'b1;
        repeat (4) @(posedge core_clk);
        vt_adj(1'b1);
        look(9'h003);
        rd_chk(REG_STATUS, 32'h0000_1fff, 32'h0000_1e03);
        vten <= 1'b0;
        repeat (4) @(posedge core_clk);
        vt_adj(1'b1);
        look(9'h003);
        wb(1'b1, REG_INIT, 32'h0000_0005);
        wb(1'b1, REG_CTRL, 32'h0000_0804);
        look(9'h005);
        rd_chk(REG_CTRL, 32'hffff_ffff, 32'h0000_0004);
        vten <= 1'b1;
        repeat (4) @(posedge core_clk);
        vt_adj(1'b1);
        look(9'h005);
        vten <= 1'b0;
        wb(1'b1, REG_INIT, 32'h0000_0082);
        wb(1'b1, REG_CTRL, 32'h0000_0800);
        look(9'h00a);
        wb(1'b1, REG_INIT, 32'h0000_07d0);
        wb(1'b1, REG_CTRL, 32'h0000_0800);
        look(9'h060);
        wb(1'b1, REG_CTRL, 32'h0000_0270);
        rd_chk(REG_CHAIN, 32'hffff_ffff, 32'h0000_00c8);
        rd_chk(REG_STATUS, 32'h0000_0800, 32'h0000_0800);
        #1;
        for (int i = 0; i < 4; i++) begin
            chk({31'h0, dout}, 32'h0, "borrowed");
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        rstn <= 1'b0;
        #1;
        chk({23'h0, tout}, 32'h0, "async reset");
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd_chk(REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
        close_out();
    end
endmodule // otdc_top_tb
